// File: cfw_clock_select.v
// Operating frequency selection, watchdog recovery and reset pulse logic.
// Assumes control bytes arrive from the link engine timed by linkClk,
// and strap pins settle before reset is released.
//
// Behaviour
// - Fixed mode: straps or soft select by override
// - Programmable mode: override picks ratio and gear source
// - Programmable mode uses 8-bit numerator, 7-bit denominator
// - Numerator or denominator writes start a frequency load while their pair drives the output
// - Recovery select: straps or recovery numerator/denominator
// - Timeout switches output to recovery frequency
// - Base select: 150 ms or 2.5 s
// - Timeout reset pulse only when enabled
// - Frequency change reset pulse only when enabled
// - Output is gear times (N+3)/(M+3)
// - Gear follows the select value in use
// - Watchdog disable clears the count; enable counts after change
`timescale 1ns/1ps
`default_nettype none
`include "cfw_defines.vh"

module cfw_clock_select #(
	parameter WD_SHORT_CYCLES = `CFW_WD_SHORT_MS * `CFW_CLK_KHZ,
	parameter WD_LONG_CYCLES  = `CFW_WD_LONG_MS * `CFW_CLK_KHZ
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [4:0]  strapFreqInputs,
	input  wire        linkClk,
	input  wire        linkWrite,
	input  wire        linkOpEnd,
	input  wire [7:0]  linkAddr,
	input  wire [7:0]  linkWrData,
	output reg  [7:0]  linkRdData,
	output reg         outProgMode,
	output reg  [4:0]  outSelect,
	output reg  [7:0]  outNumerator,
	output reg  [6:0]  outDenominator,
	output reg         freqLoad,
	output reg         recoveryActive,
	output reg         sysResetPulse
);

	// ==========================================================
	// Input synchronisers
	reg [4:0] strapMeta;
	reg [4:0] strapSync;
	reg [2:0] linkCtlMeta;
	reg [2:0] linkCtlSync;
	reg [15:0] linkBusMeta;
	reg [15:0] linkBusSync;
	reg        linkClkLast;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strapMeta   <= 5'h00;
			strapSync   <= 5'h00;
			linkCtlMeta <= 3'h0;
			linkCtlSync <= 3'h0;
			linkBusMeta <= 16'h0000;
			linkBusSync <= 16'h0000;
			linkClkLast <= 1'b0;
		end else begin
			strapMeta   <= strapFreqInputs;
			strapSync   <= strapMeta;
			linkCtlMeta <= {linkClk, linkWrite, linkOpEnd};
			linkCtlSync <= linkCtlMeta;
			linkBusMeta <= {linkAddr, linkWrData};
			linkBusSync <= linkBusMeta;
			linkClkLast <= linkCtlSync[2];
		end
	end

	// Link fields are stable around the link clock rising edge
	wire       linkRise  = linkCtlSync[2] & ~linkClkLast;
	wire       wrStrobe  = linkRise & linkCtlSync[1];
	wire       opEnd     = linkRise & linkCtlSync[0];
	wire [7:0] wrAddr    = linkBusSync[15:8];
	wire [7:0] wrData    = linkBusSync[7:0];

	// ==========================================================
	// Strap latch, sampled for three cycles after reset release, then held
	reg [4:0] latchedStrap;
	reg [1:0] settleCount;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latchedStrap <= 5'h00;
			settleCount  <= 2'd0;
		end else if (settleCount != `CFW_STRAP_SETTLE) begin
			settleCount  <= settleCount + 2'd1;
			latchedStrap <= strapSync;
		end
	end

	wire strapReady = (settleCount == `CFW_STRAP_SETTLE);

	// ==========================================================
	// Control bytes
	reg [`CFW_CTRL_WIDTH-1:0] ctrl;
	reg [4:0] softSelect;
	reg [7:0] cpuNumerator;
	reg [6:0] cpuDenominator;
	reg [7:0] recoveryNumerator;
	reg [6:0] recoveryDenominator;
	reg       cpuPending;
	reg       recPending;

	wire progEnable      = ctrl[`CFW_CTRL_PROG];
	wire strapOverride   = ctrl[`CFW_CTRL_OVERRIDE];
	wire recoverySource  = ctrl[`CFW_CTRL_RECSEL];
	wire timeoutBaseSel  = ctrl[`CFW_CTRL_BASESEL];
	wire timeoutResetEn  = ctrl[`CFW_CTRL_WDRST];
	wire changeResetEn   = ctrl[`CFW_CTRL_FCRST];
	wire timeoutCountEn  = ctrl[`CFW_CTRL_WDEN];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl                <= `CFW_CTRL_RESET;
			softSelect          <= `CFW_SELECT_RESET;
			cpuNumerator        <= `CFW_NUM_RESET;
			cpuDenominator      <= `CFW_DEN_RESET;
			recoveryNumerator   <= `CFW_NUM_RESET;
			recoveryDenominator <= `CFW_DEN_RESET;
			cpuPending          <= 1'b0;
			recPending          <= 1'b0;
		end else begin
			// Loads wait for end of operation so a word write
			// never applies half a pair
			if (opEnd) begin
				cpuPending <= 1'b0;
				recPending <= 1'b0;
			end
			if (wrStrobe) begin
				case (wrAddr)
				`CFW_ADDR_CTRL: begin
					ctrl        <= wrData[`CFW_CTRL_WIDTH-1:0];
				end
				`CFW_ADDR_SELECT: begin
					softSelect <= wrData[4:0];
				end
				`CFW_ADDR_CPU_NUM: begin
					cpuNumerator <= wrData;
					cpuPending   <= 1'b1;
				end
				`CFW_ADDR_CPU_DEN: begin
					cpuDenominator <= wrData[6:0];
					cpuPending     <= 1'b1;
				end
				`CFW_ADDR_REC_NUM: begin
					recoveryNumerator <= wrData;
					recPending        <= 1'b1;
				end
				`CFW_ADDR_REC_DEN: begin
					recoveryDenominator <= wrData[6:0];
					recPending          <= 1'b1;
				end
				default: begin
				end
				endcase
			end
		end
	end

	wire cpuLoad = opEnd & cpuPending;
	wire recLoad = opEnd & recPending;
	// Exit recovery with the write itself, so outputs move only once
	wire ctrlWrite = wrStrobe & (wrAddr == `CFW_ADDR_CTRL);

	// ==========================================================
	// Applied pairs, updated only when a load starts
	reg [7:0] appliedNum;
	reg [6:0] appliedDen;
	reg [7:0] appliedRecNum;
	reg [6:0] appliedRecDen;
	reg [1:0] pairApplied;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pairApplied   <= 2'b00;
			appliedNum    <= `CFW_NUM_RESET;
			appliedDen    <= `CFW_DEN_RESET;
			appliedRecNum <= `CFW_NUM_RESET;
			appliedRecDen <= `CFW_DEN_RESET;
		end else begin
			pairApplied <= {recLoad, cpuLoad};
			if (cpuLoad) begin
				appliedNum <= cpuNumerator;
				appliedDen <= cpuDenominator;
			end
			if (recLoad) begin
				appliedRecNum <= recoveryNumerator;
				appliedRecDen <= recoveryDenominator;
			end
		end
	end

	// ==========================================================
	// Frequency choice
	wire [4:0] selectInUse = strapOverride ? softSelect : latchedStrap;
	reg        next_prog;
	reg  [4:0] next_select;
	reg  [7:0] next_num;
	reg  [6:0] next_den;

	always @* begin
		next_prog   = 1'b0;
		next_select = selectInUse;
		next_num    = outNumerator;
		next_den    = outDenominator;
		if (recoveryActive) begin
			if (recoverySource) begin
				next_prog = 1'b1;
				next_num  = appliedRecNum;
				next_den  = appliedRecDen;
			end else begin
				next_select = latchedStrap;
			end
		end else if (progEnable) begin
			// Gear and ratio from select in use, N/M scale it
			next_prog = 1'b1;
			next_num  = appliedNum;
			next_den  = appliedDen;
		end
	end

	wire outChange = (next_prog != outProgMode)
		| (next_select != outSelect)
		| (next_prog & ((next_num != outNumerator)
		| (next_den != outDenominator)));
	// A rewrite of equal values still restarts the loader
	wire freqEvent = strapReady & (outChange
		| (pairApplied[0] & progEnable & ~recoveryActive)
		| (pairApplied[1] & recoverySource & recoveryActive));

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outProgMode    <= 1'b0;
			outSelect      <= 5'h00;
			outNumerator   <= `CFW_NUM_RESET;
			outDenominator <= `CFW_DEN_RESET;
			freqLoad       <= 1'b0;
		end else begin
			freqLoad <= freqEvent;
			if (strapReady) begin
				outProgMode    <= next_prog;
				outSelect      <= next_select;
				outNumerator   <= next_num;
				outDenominator <= next_den;
			end
		end
	end

	// ==========================================================
	// Watchdog and recovery
	wire timeout;
	wire wdRunning;

	cfw_watchdog #(
		.SHORT_CYCLES (WD_SHORT_CYCLES),
		.LONG_CYCLES  (WD_LONG_CYCLES)
	) watchdog (
		.clk        (clk),
		.rst_n      (rst_n),
		.enable     (timeoutCountEn),
		.baseSelect (timeoutBaseSel),
		.arm        (freqLoad),
		.timeout    (timeout),
		.running    (wdRunning)
	);

	reg timedOut;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			recoveryActive <= 1'b0;
			timedOut       <= 1'b0;
		end else begin
			// Timeout wins over a software exit in the same cycle
			if (timeout) begin
				recoveryActive <= 1'b1;
				timedOut       <= 1'b1;
			end else if (cpuLoad | ctrlWrite) begin
				recoveryActive <= 1'b0;
				if (ctrlWrite)
					timedOut <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Reset pulse generator
	reg [4:0] pulseCount;
	wire      pulseStart = (timeout & timeoutResetEn)
		| (freqLoad & changeResetEn);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulseCount    <= 5'd0;
			sysResetPulse <= 1'b0;
		end else if (pulseStart) begin
			pulseCount    <= `CFW_RST_PULSE_CYC - 5'd1;
			sysResetPulse <= 1'b1;
		end else if (pulseCount != 5'd0) begin
			pulseCount <= pulseCount - 5'd1;
		end else begin
			sysResetPulse <= 1'b0;
		end
	end

	// ==========================================================
	// Read path, registered from the synchronised address
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			linkRdData <= 8'h00;
		end else begin
			case (wrAddr)
			`CFW_ADDR_CTRL:    linkRdData <= {1'b0, ctrl};
			`CFW_ADDR_SELECT:  linkRdData <= {3'h0, softSelect};
			`CFW_ADDR_CPU_NUM: linkRdData <= cpuNumerator;
			`CFW_ADDR_CPU_DEN: linkRdData <= {1'b0, cpuDenominator};
			`CFW_ADDR_REC_NUM: linkRdData <= recoveryNumerator;
			`CFW_ADDR_REC_DEN: linkRdData <= {1'b0, recoveryDenominator};
			`CFW_ADDR_STATUS:  linkRdData <= {5'h00, wdRunning, timedOut,
				recoveryActive};
			`CFW_ADDR_STRAP:   linkRdData <= {3'h0, latchedStrap};
			default:           linkRdData <= 8'h00;
			endcase
		end
	end

endmodule

`default_nettype wire

// File: cfw_defines.vh
// Constants for the clock select and watchdog control block.
// Assumes a 10 MHz block clock and control bytes written over the link.
`ifndef CFW_DEFINES_VH
`define CFW_DEFINES_VH

// ==========================================================
// Control byte offsets
`define CFW_ADDR_CTRL      8'h00
`define CFW_ADDR_SELECT    8'h01
`define CFW_ADDR_CPU_NUM   8'h02
`define CFW_ADDR_CPU_DEN   8'h03
`define CFW_ADDR_REC_NUM   8'h04
`define CFW_ADDR_REC_DEN   8'h05
`define CFW_ADDR_STATUS    8'h06
`define CFW_ADDR_STRAP     8'h07

// ==========================================================
// Control byte fields
`define CFW_CTRL_PROG      0
`define CFW_CTRL_OVERRIDE  1
`define CFW_CTRL_RECSEL    2
`define CFW_CTRL_BASESEL   3
`define CFW_CTRL_WDRST     4
`define CFW_CTRL_FCRST     5
`define CFW_CTRL_WDEN      6
`define CFW_CTRL_WIDTH     7

// ==========================================================
// Reset values
`define CFW_CTRL_RESET     7'h00
`define CFW_SELECT_RESET   5'h00
`define CFW_NUM_RESET      8'h00
`define CFW_DEN_RESET      7'h00

// ==========================================================
// Timing
`define CFW_CLK_KHZ        10000
`define CFW_WD_SHORT_MS    150
`define CFW_WD_LONG_MS     2500
`define CFW_RST_PULSE_CYC  5'd16
`define CFW_STRAP_SETTLE   2'd3

`endif

// File: cfw_watchdog.v
// Watchdog down-counter with two selectable time bases.
// Assumes arm and enable come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cfw_defines.vh"

module cfw_watchdog #(
	parameter SHORT_CYCLES = `CFW_WD_SHORT_MS * `CFW_CLK_KHZ,
	parameter LONG_CYCLES  = `CFW_WD_LONG_MS * `CFW_CLK_KHZ
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        enable,
	input  wire        baseSelect,
	input  wire        arm,
	output reg         timeout,
	output reg         running
);

	reg [24:0] count;

	// ==========================================================
	// Countdown
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count   <= 25'h0;
			running <= 1'b0;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (!enable) begin
				// Stop and clear the count
				running <= 1'b0;
				count   <= 25'h0;
			end else if (arm) begin
				// Restart on each frequency change
				running <= 1'b1;
				if (baseSelect)
					count <= LONG_CYCLES[24:0] - 25'h1;
				else
					count <= SHORT_CYCLES[24:0] - 25'h1;
			end else if (running) begin
				if (count == 25'h0) begin
					running <= 1'b0;
					timeout <= 1'b1;
				end else begin
					count <= count - 25'h1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// File: cfw_chk.sv
// Checker on the clock select block's outputs.
// Assumes a bind to cfw_clock_select; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cfw_chk (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       outProgMode,
	input wire logic [4:0] outSelect,
	input wire logic [7:0] outNumerator,
	input wire logic [6:0] outDenominator,
	input wire logic       freqLoad,
	input wire logic       recoveryActive,
	input wire logic       sysResetPulse
);
	// ==========
	// Pulse length so far
	logic [4:0] pulseLen;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pulseLen <= 5'h00;
		else if (sysResetPulse)
			pulseLen <= pulseLen + 5'h01;
		else
			pulseLen <= 5'h00;
	end
	// ==========
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_loadOnce;
		freqLoad ##1 !freqLoad;
	endsequence
	sequence s_outMoved;
		$changed(outSelect) || $changed(outProgMode)
			|| $changed(outNumerator) || $changed(outDenominator);
	endsequence
	a_load_single: assert property (freqLoad |-> s_loadOnce)
		else $error("load strobe longer than one cycle");
	a_load_on_change: assert property (s_outMoved |-> freqLoad)
		else $error("outputs moved without a load strobe");
	a_pulse_width: assert property ($fell(sysResetPulse)
		|-> pulseLen == 5'd16)
		else $error("reset pulse width wrong");
	a_pulse_max: assert property (sysResetPulse |-> pulseLen < 5'd16)
		else $error("reset pulse too long");
	a_pulse_cause: assert property ($rose(sysResetPulse)
		|-> recoveryActive || $past(freqLoad))
		else $error("reset pulse without a cause");
	a_recovery_load: assert property ($rose(recoveryActive)
		|-> ##[1:3] freqLoad)
		else $error("recovery entered without a load");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n
		|-> !freqLoad && !sysResetPulse && !recoveryActive && !outProgMode)
		else $error("outputs active in reset");
	a_strap_settle: assert property ($rose(rst_n) |-> (!freqLoad)[*3])
		else $error("load during strap settling");
endmodule
`default_nettype wire

// File: cfw_link_host.sv
// Link host model driving control byte writes and reads.
// Assumes clk is the block clock; link clock idles low.
`timescale 1ns/1ps
`default_nettype none
module cfw_link_host (
	input  wire logic       clk,
	output var  logic       linkClk,
	output var  logic       linkWrite,
	output var  logic       linkOpEnd,
	output var  logic [7:0] linkAddr,
	output var  logic [7:0] linkWrData
);
	initial begin
		linkClk = 1'b0;
		linkWrite = 1'b0;
		linkOpEnd = 1'b0;
		linkAddr = 8'h00;
		linkWrData = 8'h00;
	end
	// ==========
	// One 800 ns beat; fields held around the rise
	task automatic beat(input logic w, e, input logic [7:0] a, d);
		@(posedge clk);
		linkWrite <= w;
		linkOpEnd <= e;
		linkAddr <= a;
		linkWrData <= d;
		repeat (3) @(posedge clk);
		linkClk <= 1'b1;
		repeat (4) @(posedge clk);
		linkClk <= 1'b0;
		linkWrite <= 1'b0;
		linkOpEnd <= 1'b0;
		// Stale data must not look valid
		linkWrData <= ~d;
	endtask
	task automatic look(input logic [7:0] a);
		@(posedge clk);
		linkAddr <= a;
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Testbench for the clock select block with a link host model.
// Assumes the design files and cfw_defines.vh compile first.
`include "cfw_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int SH = 50;
	localparam int LG = 200;
	logic       clk, rst_n, linkClk, linkWrite, linkOpEnd, recPrev, pulPrev;
	logic       outProgMode, freqLoad, recoveryActive, sysResetPulse;
	logic [4:0] strap, outSelect;
	logic [6:0] outDenominator;
	logic [7:0] linkAddr, linkWrData, linkRdData, outNumerator, pend[$];
	logic [7:0] mReg[8] = '{default: 8'h00};
	logic [7:0] msk[6] = '{8'h7f, 8'h1f, 8'hff, 8'h7f, 8'hff, 8'h7f};
	logic [31:0] seed = 32'haa1c8d26;
	int errorCnt, samplesChecked, cyc, lastLoad, gap, loads, pulses, p0;
	cfw_clock_select #(.WD_SHORT_CYCLES(SH), .WD_LONG_CYCLES(LG)) i_dut (
		.clk(clk), .rst_n(rst_n), .strapFreqInputs(strap),
		.linkClk(linkClk), .linkWrite(linkWrite), .linkOpEnd(linkOpEnd),
		.linkAddr(linkAddr), .linkWrData(linkWrData),
		.linkRdData(linkRdData), .outProgMode(outProgMode),
		.outSelect(outSelect), .outNumerator(outNumerator),
		.outDenominator(outDenominator), .freqLoad(freqLoad),
		.recoveryActive(recoveryActive), .sysResetPulse(sysResetPulse));
	cfw_link_host i_host (.clk(clk), .linkClk(linkClk),
		.linkWrite(linkWrite), .linkOpEnd(linkOpEnd),
		.linkAddr(linkAddr), .linkWrData(linkWrData));
	// ==========
	// Helpers
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] got, exp);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Whole operation, then the end on a later beat
	task automatic op();
		while (pend.size() > 1) begin
			i_host.beat(1'b1, 1'b0, pend[0], pend[1]);
			if (pend[0] < 8'h06)
				mReg[pend[0][2:0]] = pend[1] & msk[pend[0][2:0]];
			void'(pend.pop_front());
			void'(pend.pop_front());
		end
		i_host.beat(1'b0, 1'b1, 8'h07, 8'h00);
		repeat (8) @(posedge clk);
	endtask
	task automatic outs(input logic rec);
		logic       p;
		logic [4:0] s;
		p = rec ? mReg[0][2] : mReg[0][0];
		s = (mReg[0][1] && !(rec && !mReg[0][2])) ? mReg[1][4:0] : strap;
		chk(8'(outProgMode), 8'(p));
		chk(8'(outSelect), 8'(s));
		if (p) begin
			chk(outNumerator, rec ? mReg[4] : mReg[2]);
			chk(8'(outDenominator), rec ? mReg[5] : mReg[3]);
		end
	endtask
	task automatic waitRec();
		for (int i = 0; i < 1000 && recoveryActive !== 1'b1; i++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		chk(8'(recoveryActive), 8'h01);
		i_host.look(8'h06);
		chk(linkRdData & 8'h03, 8'h03);
	endtask
	// ==========
	// Clock, monitor, watchdog
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(negedge clk) begin
		cyc++;
		if (freqLoad === 1'b1) begin
			loads++;
			lastLoad = cyc;
		end
		if (recoveryActive === 1'b1 && recPrev !== 1'b1)
			gap = cyc - lastLoad;
		if (sysResetPulse === 1'b1 && pulPrev !== 1'b1)
			pulses++;
		recPrev = recoveryActive;
		pulPrev = sysResetPulse;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errorCnt++;
		final_report();
	end
	// ==========
	// Tests
	initial begin
		rst_n = 1'b0;
		strap = 5'(rnd()) | 5'h01;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		for (int a = 0; a < 9; a++) begin
			i_host.look(8'(a));
			chk(linkRdData, a == 7 ? 8'(strap) : a < 6 ? mReg[a] : 8'h00);
		end
		outs(1'b0);
		pend = {8'h00, 8'h02, 8'h01, rnd(), 8'h07, 8'hff};
		op();
		outs(1'b0);
		i_host.look(8'h07);
		chk(linkRdData, 8'(strap));
		$display("test reset and select done");
		for (int v = 0; v < 2; v++) begin
			pend = {8'h00, 8'(1 + 2 * v)};
			op();
			// Keeps (N+3)/(M+3) above one
			pend = {8'h02, rnd() | 8'h80, 8'h03, rnd() & 8'h7f};
			p0 = loads;
			op();
			outs(1'b0);
			chk(8'(loads - p0), 8'h01);
		end
		for (int e = 0; e < 2; e++) begin
			p0 = pulses;
			pend = {8'h00, 8'(3 + 32 * e), 8'h02, rnd() | 8'h80};
			op();
			repeat (20) @(posedge clk);
			chk(8'(pulses - p0), 8'(e));
		end
		$display("test programmed mode done");
		pend = {8'h04, rnd() | 8'h80, 8'h05, rnd() & 8'h7f};
		op();
		p0 = pulses;
		pend = {8'h00, 8'h57, 8'h02, rnd() | 8'h80, 8'h03, rnd() & 8'h7f};
		op();
		waitRec();
		outs(1'b1);
		chk(8'(gap >= SH && gap <= SH + 4), 8'h01);
		chk(8'(pulses - p0), 8'h01);
		p0 = pulses;
		pend = {8'h00, 8'h49, 8'h02, rnd() | 8'h80, 8'h03, rnd() & 8'h7f};
		op();
		outs(1'b0);
		waitRec();
		outs(1'b1);
		chk(8'(gap >= LG && gap <= LG + 4), 8'h01);
		chk(8'(pulses - p0), 8'h00);
		pend = {8'h00, 8'h01, 8'h02, rnd() | 8'h80};
		op();
		repeat (300) @(posedge clk);
		chk(8'(recoveryActive), 8'h00);
		$display("test watchdog done");
		final_report();
	end
endmodule
bind cfw_clock_select cfw_chk i_chk (.clk(clk), .rst_n(rst_n),
	.outProgMode(outProgMode), .outSelect(outSelect),
	.outNumerator(outNumerator), .outDenominator(outDenominator),
	.freqLoad(freqLoad), .recoveryActive(recoveryActive),
	.sysResetPulse(sysResetPulse));
`default_nettype wire
